// ===== verilog/mmhbp_pkg.sv
`default_nettype none

package mmhbp_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int UPPER_W = 16;
    localparam int ADDR_W = 17;
    localparam int BE_W = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BCLK_PERIOD_NS = 160;
    localparam int BCLK_HALF_RAW = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int BCLK_HALF_CYC = (BCLK_HALF_RAW < 1) ? 1 : BCLK_HALF_RAW;
    localparam int DATA_PERIODS = 4;
    localparam int CFG_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Byte enables and pin levels
    // ------------------------------------------------------------
    localparam logic [1:0] BE_NONE = 2'h0;
    localparam logic [1:0] BE_LO = 2'h1;
    localparam logic [1:0] BE_HI = 2'h2;
    localparam logic [1:0] BE_BOTH = 2'h3;
    localparam logic PIN_HI = 1'h1;
    localparam logic PIN_LO = 1'h0;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    localparam logic [15:0] BUS_PULLUP = 16'hFFFF;

    // ------------------------------------------------------------
    // Host bus styles, fixed by a strap at reset
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        START_STROBE_STYLE = 3'h0,
        FIRST_ASYNC_STYLE = 3'h1,
        DYNAMIC_SIZE_STYLE = 3'h2,
        BYTE_CMD_STYLE = 3'h3,
        SINGLE_CMD_STYLE = 3'h4
    } mmhbp_style_t;

    // Host pins as seen by the device, sampled as one group
    typedef struct packed {
        logic bclk;
        logic cs_n;
        logic addr_low_bit_pin;
        logic [UPPER_W-1:0] upper_address_pins;
        logic first_write_input;
        logic second_write_input;
        logic bus_start_input;
        logic direction_input;
        logic [DATA_W-1:0] host_data_bus;
    } mmhbp_pins_t;

endpackage : mmhbp_pkg

`default_nettype wire

// ===== verilog/mmhbp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mmhbp_if;
    import mmhbp_pkg::*;

    // ------------------------------------------------------------
    // Host bus pins
    // ------------------------------------------------------------
    logic bclk;
    logic cs_n;
    logic addr_low_bit_pin;
    logic [UPPER_W-1:0] upper_address_pins;
    logic first_write_input;
    logic second_write_input;
    logic bus_start_input;
    logic direction_input;
    logic [DATA_W-1:0] host_data_out;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data_out;
    logic dev_data_oe;
    logic [DATA_W-1:0] host_data_bus;

    // Resolved data bus level; an undriven bus floats high
    assign host_data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : BUS_PULLUP);

    modport dev (
        input bclk, cs_n, addr_low_bit_pin, upper_address_pins, first_write_input,
        input second_write_input, bus_start_input, direction_input, host_data_bus,
        output dev_data_out, dev_data_oe
    );

    modport host (
        output bclk, cs_n, addr_low_bit_pin, upper_address_pins, first_write_input,
        output second_write_input, bus_start_input, direction_input, host_data_out, host_data_oe,
        input host_data_bus
    );

endinterface : mmhbp_if

`default_nettype wire

// ===== verilog/mmhbp_dev_end.sv
// Notes on behaviour
// R01: Low address pin is bit 0, strobe in async
// R02: Upper address pins carry address bits 16..1
// R03: Wide host wires data to its upper lanes
// R04: Data bus undriven in reset; driven for reads, except in single-command style, which never drives it
// R05: First write pin meaning depends on style
// R06: Second write pin meaning depends on style
// R07: Ignore all activity while chip select high
// R08: Bus sampling is timed from bus clock pin
// R09: Bus start pin: start or address strobe
// R10: Direction sampled at start for early decode
// R11: Byte-command: direction is upper read command
// R12: Style fixed at reset, never changes after
// R13: Reset clears state and idles every output
`timescale 1ns/1ps
`default_nettype none

module mmhbp_dev_end
    import mmhbp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Style strap, caught after reset release
    input wire logic [2:0] style_sel,
    // Host bus pins
    mmhbp_if.dev bus,
    // User side access port
    output logic acc_valid,
    output logic acc_write,
    output logic [ADDR_W-1:0] acc_addr,
    output logic [BE_W-1:0] acc_be,
    output logic [DATA_W-1:0] acc_wdata,
    input wire logic [DATA_W-1:0] rd_data,
    output mmhbp_style_t style
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ADDRESSED = 2'h1,
        ST_DRIVE = 2'h2,
        ST_HOLD = 2'h3
    } mmhbp_dev_fsm_t;

    typedef struct packed {
        mmhbp_pins_t s1;
        mmhbp_pins_t s2;
        logic bclk_prev;
        logic [2:0] strap1;
        logic [2:0] strap2;
        logic [1:0] cfg_cnt;
        logic cfg_done;
        mmhbp_style_t style;
        mmhbp_dev_fsm_t fsm;
        logic dir_rd;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0] be;
        logic [DATA_W-1:0] wdata;
        logic acc_valid;
        logic acc_write;
        logic [DATA_W-1:0] dout;
        logic oe;
    } mmhbp_dev_state_t;

    mmhbp_dev_state_t st_q;
    mmhbp_dev_state_t st_d;
    mmhbp_pins_t raw;

    // Gather pins into one group for the synchroniser
    always_comb begin
        raw.bclk = bus.bclk;
        raw.cs_n = bus.cs_n;
        raw.addr_low_bit_pin = bus.addr_low_bit_pin;
        raw.upper_address_pins = bus.upper_address_pins;
        raw.first_write_input = bus.first_write_input;
        raw.second_write_input = bus.second_write_input;
        raw.bus_start_input = bus.bus_start_input;
        raw.direction_input = bus.direction_input;
        raw.host_data_bus = bus.host_data_bus;
    end

    // ------------------------------------------------------------
    // Per style pin decode, from synchronised pins only
    // ------------------------------------------------------------
    logic rise;
    logic sel;
    logic has_start;
    logic start_act;
    logic lo_act;
    logic hi_act;
    logic rd_req;
    logic cyc_end;
    logic abit0;

    always_comb begin
        rise = st_q.s2.bclk & ~st_q.bclk_prev; // R08
        sel = ~st_q.s2.cs_n; // R07
        start_act = ~st_q.s2.bus_start_input; // R09
        has_start = 1'b0;
        lo_act = 1'b0;
        hi_act = 1'b0;
        rd_req = 1'b0;
        abit0 = st_q.s2.addr_low_bit_pin; // R01
        cyc_end = st_q.s2.cs_n;
        unique case (st_q.style)
            START_STROBE_STYLE: begin
                has_start = 1'b1;
                lo_act = ~st_q.s2.first_write_input; // R05
                hi_act = ~st_q.s2.second_write_input; // R06
            end
            FIRST_ASYNC_STYLE: begin
                has_start = 1'b1;
                lo_act = ~st_q.s2.addr_low_bit_pin; // R01
                hi_act = ~st_q.s2.second_write_input; // R06
                abit0 = PIN_LO; // R01
                cyc_end = st_q.s2.cs_n | st_q.s2.bus_start_input; // R09
            end
            DYNAMIC_SIZE_STYLE: begin
                // Size bit 0 high means a byte; the low address pin picks the lane
                has_start = 1'b1;
                lo_act = ~st_q.s2.second_write_input &
                    (~st_q.s2.first_write_input | st_q.s2.addr_low_bit_pin); // R05 R06
                hi_act = ~st_q.s2.second_write_input &
                    (~st_q.s2.first_write_input | ~st_q.s2.addr_low_bit_pin); // R05 R06
                cyc_end = st_q.s2.cs_n | st_q.s2.bus_start_input; // R09
            end
            BYTE_CMD_STYLE: begin
                lo_act = ~st_q.s2.first_write_input; // R05
                hi_act = ~st_q.s2.second_write_input; // R06
                rd_req = ~st_q.s2.direction_input; // R11
                cyc_end = st_q.s2.cs_n | st_q.s2.direction_input; // R11
            end
            SINGLE_CMD_STYLE: begin
                // One write strobe; low address pin low and high byte enable pick lanes
                lo_act = ~st_q.s2.first_write_input & ~st_q.s2.addr_low_bit_pin; // R05
                hi_act = ~st_q.s2.first_write_input & ~st_q.s2.second_write_input; // R06
            end
            default: begin
                has_start = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
        st_d.bclk_prev = st_q.s2.bclk;
        st_d.strap1 = style_sel;
        st_d.strap2 = st_q.strap1;
        st_d.acc_valid = 1'b0;
        // Strap is taken once, after it has passed the synchroniser
        if (!st_q.cfg_done) begin
            if (st_q.cfg_cnt == 2'(CFG_SYNC_STAGES)) begin
                st_d.cfg_done = 1'b1; // R12
                st_d.style = (st_q.strap2 > SINGLE_CMD_STYLE) ? START_STROBE_STYLE
                    : mmhbp_style_t'(st_q.strap2); // R12
            end else begin
                st_d.cfg_cnt = st_q.cfg_cnt + 2'h1;
            end
        end
        unique case (st_q.fsm)
            ST_IDLE: begin
                if (st_q.cfg_done && rise && sel) begin // R07
                    st_d.addr = {st_q.s2.upper_address_pins, abit0}; // R02
                    if (has_start) begin
                        if (start_act) begin
                            st_d.dir_rd = st_q.s2.direction_input; // R10
                            st_d.fsm = ST_ADDRESSED;
                        end
                    end else if (lo_act || hi_act) begin
                        st_d.be = {hi_act, lo_act};
                        st_d.wdata = st_q.s2.host_data_bus;
                        st_d.acc_write = 1'b1;
                        st_d.acc_valid = 1'b1;
                        st_d.fsm = ST_HOLD;
                    end else if (rd_req) begin
                        st_d.be = BE_HI; // R11
                        st_d.acc_write = 1'b0;
                        st_d.acc_valid = 1'b1;
                        st_d.fsm = ST_DRIVE;
                    end
                end
            end
            ST_ADDRESSED: begin
                if (!sel) begin
                    st_d.fsm = ST_IDLE; // R07
                end else if (st_q.dir_rd) begin
                    // Read is known from the start phase, so the fetch begins at once
                    st_d.be = BE_BOTH; // R10
                    st_d.acc_write = 1'b0;
                    st_d.acc_valid = 1'b1;
                    st_d.fsm = ST_DRIVE;
                end else if (rise && (lo_act || hi_act)) begin
                    st_d.be = {hi_act, lo_act};
                    st_d.wdata = st_q.s2.host_data_bus;
                    st_d.acc_write = 1'b1;
                    st_d.acc_valid = 1'b1;
                    st_d.fsm = ST_HOLD;
                end
            end
            ST_DRIVE: begin
                if (cyc_end) begin
                    st_d.fsm = ST_IDLE;
                end
            end
            ST_HOLD: begin
                // Write ends when its strobes drop; the direction pin has no say here
                if (!sel || !(lo_act || hi_act)) begin // R07
                    st_d.fsm = ST_IDLE;
                end
            end
        endcase
        // Data bus is driven only while a read is being answered
        st_d.oe = (st_d.fsm == ST_DRIVE); // R04
        st_d.dout = (st_q.fsm == ST_DRIVE) ? rd_data : DATA_ZERO; // R03
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0; // R13 R04
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign bus.dev_data_out = st_q.dout;
    assign bus.dev_data_oe = st_q.oe; // R04
    assign acc_valid = st_q.acc_valid;
    assign acc_write = st_q.acc_write;
    assign acc_addr = st_q.addr;
    assign acc_be = st_q.be;
    assign acc_wdata = st_q.wdata;
    assign style = st_q.style;

endmodule : mmhbp_dev_end

`default_nettype wire

// ===== verilog/mmhbp_host_end.sv
`timescale 1ns/1ps
`default_nettype none

module mmhbp_host_end
    import mmhbp_pkg::*;
#(
    parameter int HALF_CYC = BCLK_HALF_CYC,
    parameter int PERIODS = DATA_PERIODS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Style select, held static
    input wire logic [2:0] style_sel,
    // Host bus pins
    mmhbp_if.host bus,
    // User command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [BE_W-1:0] cmd_be,
    input wire logic [DATA_W-1:0] cmd_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_WAIT = 3'h1,
        HS_ADDR = 3'h2,
        HS_DATA = 3'h3,
        HS_END = 3'h4
    } mmhbp_host_fsm_t;

    typedef struct packed {
        logic [7:0] div;
        logic bclk;
        logic cfg_done;
        mmhbp_style_t style;
        mmhbp_host_fsm_t fsm;
        logic [7:0] periods;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0] be;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] d1;
        logic [DATA_W-1:0] d2;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic cs_n;
        logic a0;
        logic we0;
        logic we1;
        logic bs;
        logic dir;
        logic oe;
    } mmhbp_host_state_t;

    mmhbp_host_state_t st_q;
    mmhbp_host_state_t st_d;
    logic fall;

    // ------------------------------------------------------------
    // Bus clock divider and transfer sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.d1 = bus.host_data_bus; // R03
        st_d.d2 = st_q.d1;
        st_d.rsp_valid = 1'b0;
        fall = 1'b0;
        if (st_q.div == 8'(HALF_CYC - 1)) begin
            st_d.div = 8'h00;
            st_d.bclk = ~st_q.bclk; // R08
            fall = st_q.bclk;
        end else begin
            st_d.div = st_q.div + 8'h01;
        end
        if (!st_q.cfg_done) begin
            st_d.cfg_done = 1'b1;
            st_d.style = (style_sel > SINGLE_CMD_STYLE) ? START_STROBE_STYLE : mmhbp_style_t'(style_sel);
        end
        unique case (st_q.fsm)
            HS_IDLE: begin
                // Idle pin levels, with the ties that each style asks for
                st_d.cs_n = PIN_HI;
                st_d.oe = 1'b0;
                st_d.we1 = PIN_HI;
                st_d.we0 = PIN_HI; // R05
                st_d.dir = PIN_HI; // R11
                st_d.bs = (st_q.style == BYTE_CMD_STYLE) ? PIN_LO : PIN_HI; // R09
                st_d.a0 = (st_q.style == FIRST_ASYNC_STYLE) ? PIN_HI : PIN_LO;
                if (st_q.cfg_done && cmd_valid) begin
                    st_d.write = cmd_write;
                    st_d.addr = cmd_addr;
                    st_d.be = cmd_be;
                    st_d.wdata = cmd_wdata;
                    st_d.fsm = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (fall) begin
                    st_d.cs_n = PIN_LO;
                    st_d.oe = st_q.write;
                    st_d.a0 = st_q.addr[0];
                    st_d.fsm = HS_ADDR;
                    unique case (st_q.style)
                        START_STROBE_STYLE, FIRST_ASYNC_STYLE, DYNAMIC_SIZE_STYLE: begin
                            st_d.bs = PIN_LO; // R09
                            st_d.dir = ~st_q.write; // R10
                            if (st_q.style == FIRST_ASYNC_STYLE) begin
                                st_d.a0 = PIN_HI;
                            end
                            if (st_q.style == DYNAMIC_SIZE_STYLE) begin
                                st_d.a0 = (st_q.be == BE_LO);
                                st_d.we0 = (st_q.be != BE_BOTH); // R05
                            end
                        end
                        SINGLE_CMD_STYLE: begin
                            st_d.a0 = ~st_q.be[0];
                            st_d.we1 = ~st_q.be[1]; // R06
                        end
                        default: begin
                        end
                    endcase
                end
            end
            HS_ADDR: begin
                if (fall) begin
                    st_d.periods = 8'(PERIODS);
                    st_d.fsm = HS_DATA;
                    unique case (st_q.style)
                        START_STROBE_STYLE: begin
                            st_d.bs = PIN_HI;
                            st_d.we0 = ~(st_q.write & st_q.be[0]);
                            st_d.we1 = ~(st_q.write & st_q.be[1]);
                        end
                        FIRST_ASYNC_STYLE: begin
                            st_d.a0 = ~st_q.be[0]; // R01
                            st_d.we1 = ~st_q.be[1];
                        end
                        DYNAMIC_SIZE_STYLE: begin
                            st_d.we1 = PIN_LO;
                        end
                        BYTE_CMD_STYLE: begin
                            st_d.we0 = ~(st_q.write & st_q.be[0]);
                            st_d.we1 = ~(st_q.write & st_q.be[1]);
                            st_d.dir = st_q.write; // R11
                        end
                        SINGLE_CMD_STYLE: begin
                            st_d.we0 = ~st_q.write;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            HS_DATA: begin
                if (fall) begin
                    if (st_q.periods == 8'h01) begin
                        st_d.rdata = st_q.d2;
                        st_d.rsp_valid = ~st_q.write;
                        st_d.cs_n = PIN_HI;
                        st_d.oe = 1'b0;
                        st_d.we0 = PIN_HI;
                        st_d.we1 = PIN_HI;
                        st_d.dir = PIN_HI;
                        st_d.bs = (st_q.style == BYTE_CMD_STYLE) ? PIN_LO : PIN_HI;
                        st_d.a0 = (st_q.style == FIRST_ASYNC_STYLE) ? PIN_HI : PIN_LO;
                        st_d.fsm = HS_END;
                    end else begin
                        st_d.periods = st_q.periods - 8'h01;
                    end
                end
            end
            HS_END: begin
                if (fall) begin
                    st_d.fsm = HS_IDLE;
                end
            end
            default: begin
                st_d.fsm = HS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign cmd_ready = (st_q.fsm == HS_IDLE) & st_q.cfg_done;
    assign rsp_valid = st_q.rsp_valid;
    assign rsp_rdata = st_q.rdata;
    assign bus.bclk = st_q.bclk;
    assign bus.cs_n = ~st_q.cfg_done | st_q.cs_n;
    assign bus.addr_low_bit_pin = st_q.a0;
    assign bus.upper_address_pins = st_q.addr[ADDR_W-1:1]; // R02
    assign bus.first_write_input = ~st_q.cfg_done | st_q.we0;
    assign bus.second_write_input = ~st_q.cfg_done | st_q.we1;
    assign bus.bus_start_input = st_q.bs;
    assign bus.direction_input = ~st_q.cfg_done | st_q.dir;
    assign bus.host_data_out = st_q.wdata;
    assign bus.host_data_oe = st_q.oe;

endmodule : mmhbp_host_end

`default_nettype wire

// ===== tb/mmhbp_properties.sv
`timescale 1ns/1ps
`default_nettype none

module mmhbp_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host bus pins
    input wire logic bclk,
    input wire logic cs_n,
    input wire logic [15:0] upper_address_pins,
    input wire logic first_write_input,
    input wire logic second_write_input,
    input wire logic host_data_oe,
    input wire logic dev_data_oe
);
    // ------------------------------------------------------------
    // Bus pin properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_reset_idle;
        $rose(rst_n) |-> cs_n && first_write_input && second_write_input && !host_data_oe && !dev_data_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
    property p_unselected_quiet;
        cs_n [*6] |-> !dev_data_oe;
    endproperty
    a_unselected_quiet: assert property (p_unselected_quiet) else $error("device drives unselected");
    property p_dev_needs_sel;
        $rose(dev_data_oe) |-> !cs_n;
    endproperty
    a_dev_needs_sel: assert property (p_dev_needs_sel) else $error("device drive without select");
    property p_one_driver;
        dev_data_oe |-> !host_data_oe;
    endproperty
    a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
    property p_dev_release;
        $rose(dev_data_oe) |-> ##[1:300] !dev_data_oe;
    endproperty
    a_dev_release: assert property (p_dev_release) else $error("device never releases data");
    property p_bclk_high;
        $rose(bclk) |=> $stable(bclk) [*7] ##1 $fell(bclk);
    endproperty
    a_bclk_high: assert property (p_bclk_high) else $error("bus clock high phase wrong");
    property p_sel_at_fall;
        $fell(cs_n) |-> !bclk;
    endproperty
    a_sel_at_fall: assert property (p_sel_at_fall) else $error("select off bus clock fall");
    property p_addr_stable;
        !cs_n && !$past(cs_n) |-> $stable(upper_address_pins);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

    // Main scenarios reached
    c_dev_read: cover property ($rose(dev_data_oe));
    c_host_write: cover property ($rose(host_data_oe));
    c_select: cover property ($fell(cs_n));
endmodule : mmhbp_properties

`default_nettype wire

// ===== tb/multi_mode_host_bus_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none

module multi_mode_host_bus_pins_tb import mmhbp_pkg::*;;
    // ------------------------------------------------------------
    // Stimulus, model and checks
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] host_style = 3'h0;
    logic [2:0] dev_strap = 3'h0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = 17'h00000;
    logic [BE_W-1:0] cmd_be = 2'h0;
    logic [DATA_W-1:0] cmd_wdata = 16'h0000;
    logic [DATA_W-1:0] rd_data = 16'h0000;
    logic cmd_ready, rsp_valid, acc_valid, acc_write;
    logic [DATA_W-1:0] rsp_rdata, acc_wdata;
    logic [ADDR_W-1:0] acc_addr;
    logic [BE_W-1:0] acc_be;
    mmhbp_style_t style;
    logic [35:0] accq[$];
    int n_fail = 0;
    int comparisons = 0;

    always #5 clk = ~clk;
    mmhbp_if hb ();
    mmhbp_dev_end mmhbp_dev_end_inst (.clk(clk), .rst_n(rst_n), .style_sel(dev_strap), .bus(hb.dev),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr), .acc_be(acc_be),
        .acc_wdata(acc_wdata), .rd_data(rd_data), .style(style));
    mmhbp_host_end #(.HALF_CYC(8), .PERIODS(4)) mmhbp_host_end_inst (.clk(clk), .rst_n(rst_n),
        .style_sel(host_style), .bus(hb.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    mmhbp_properties chk (.clk(clk), .rst_n(rst_n), .bclk(hb.bclk), .cs_n(hb.cs_n),
        .upper_address_pins(hb.upper_address_pins), .first_write_input(hb.first_write_input),
        .second_write_input(hb.second_write_input), .host_data_oe(hb.host_data_oe),
        .dev_data_oe(hb.dev_data_oe));

    // Memory model answers reads from the decoded address
    always @(posedge clk) rd_data <= acc_addr[15:0] ^ 16'h5A3C;
    // Record every access the device decodes
    always @(negedge clk) if (acc_valid === 1'b1) accq.push_back({acc_write, acc_be, acc_addr, acc_wdata});

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // One host command, held until taken, then settle time for the device side
    task automatic do_cmd(input logic w, input logic [16:0] a, input logic [1:0] be, input logic [15:0] d,
                          output logic [15:0] r);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_be <= be;
        cmd_wdata <= d;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 3000);
        if (n >= 3000) n_fail++;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) n_fail++;
        r = rsp_rdata;
        repeat (100) @(negedge clk);
    endtask : do_cmd

    // Watchdog
    initial begin
        #300000;
        n_fail++;
        stop_test();
    end

    // Every style, each after its own reset
    initial begin
        logic [16:0] a;
        logic [15:0] d, r, x;
        logic [1:0] be;
        logic [35:0] e;
        void'($urandom(32'h9a93));
        for (int s = 0; s < 5; s++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            host_style <= 3'(s);
            dev_strap <= 3'(s);
            repeat (8) @(posedge clk);
            check("acc_valid", acc_valid, 1'b0);
            check("dev_oe", hb.dev_data_oe, 1'b0);
            rst_n <= 1'b1;
            repeat (8) @(posedge clk);
            dev_strap <= 3'((s + 1) % 5);
            repeat (4) @(posedge clk);
            check("style", style, s);
            accq.delete();
            for (int i = 0; i < 4; i++) begin
                a = 17'($urandom);
                // All accesses in these styles sit on even addresses, byte or word in style 1, word only in styles 2 and 4
                if (s == 1 || s == 2 || s == 4) a[0] = 1'b0;
                d = 16'($urandom);
                be = (s == 2 || s == 4) ? BE_BOTH : 2'($urandom_range(1, 3));
                x = a[15:0] ^ 16'h5A3C;
                do_cmd(1'b1, a, be, d, r);
                check("wr count", accq.size(), 1);
                e = (accq.size() > 0) ? accq.pop_front() : 36'h0;
                check("wr flag", e[35], 1'b1);
                check("wr addr", e[32:17], a[16:1]);
                check("wr bit0", e[16], a[0]);
                check("wr data", e[15:0], d);
                check("wr be", e[34:33], be);
                do_cmd(1'b0, a, BE_BOTH, 16'h0000, r);
                check("rd count", accq.size(), (s == 4) ? 0 : 1);
                e = (accq.size() > 0) ? accq.pop_front() : 36'h0;
                if (s != 4) check("rd flag", e[35], 1'b0);
                if (s == 3) check("rd be", e[34:33], 2'h2);
                if (s == 4) check("rd data", r, 16'hFFFF);
                else if (s == 3) check("rd data", r[15:8], x[15:8]);
                else check("rd data", r, x);
            end
        end
        stop_test();
    end
endmodule : multi_mode_host_bus_pins_tb

`default_nettype wire
